// file: src/controller_error_classifier.sv
// Purpose: Classify CPU error conditions, drive indicators, post alarm codes and flags.
// Assumes: Condition inputs are synchronous levels; instruction strobes are one-cycle pulses.
// Notes: APB slave with zero wait states; unmapped addresses answer pslverr.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module controller_error_classifier #(
  parameter int CYCLES_PER_MS = err_class_pkg::CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startInput,
  input wire logic remotePowerOk,
  input wire logic [3:0] terminatorCount,
  input wire logic supplyLost,
  input wire logic cycleEnd,
  input wire logic nonfatal_alarm_instr,
  input wire logic fatal_alarm_instr,
  input wire logic [7:0] user_alarm_code,
  input wire logic [19:0] instrAddress,
  input wire err_class_pkg::fault_in_t faults,
  output err_class_pkg::front_t front
);

  // Pending code lookup: first non-fatal cause newly raised this cycle
  function automatic logic [7:0] pick_code(input logic [5:0] rise, input logic [2:0] unit);
    logic [7:0] c;
    c = err_class_pkg::CODE_NONE;
    if (rise[0]) begin
      c = err_class_pkg::CODE_CYCLE_OVERRUN;
    end else if (rise[1]) begin
      c = err_class_pkg::CODE_IO_VERIFY;
    end else if (rise[2]) begin
      c = err_class_pkg::CODE_REMOTE_BASE | {5'h00, unit};
    end else if (rise[3]) begin
      c = err_class_pkg::CODE_DUAL_CPU;
    end else if (rise[4]) begin
      c = err_class_pkg::CODE_BATTERY;
    end
    return c;
  endfunction

  err_class_pkg::phase_t phase, next_phase;
  logic [1:0] mode, next_mode;
  logic [7:0] wdMax, next_wdMax;
  logic [7:0] alarmCode, next_alarmCode;
  logic [7:0] pend [err_class_pkg::PEND_DEPTH];
  logic [7:0] next_pend [err_class_pkg::PEND_DEPTH];
  logic [2:0] pendCount, next_pendCount;
  logic [15:0] sr253, next_sr253;
  logic [15:0] sr254, next_sr254;
  logic [15:0] sr255, next_sr255;
  logic [19:0] fatalAddr, next_fatalAddr;
  logic [31:0] msPre, next_msPre;
  logic [7:0] cycleMs, next_cycleMs;
  logic [7:0] lossMs, next_lossMs;
  logic powerDown, next_powerDown;
  logic [31:0] rdata, next_rdata;
  logic accessWrite, setupRead, clearReq, addrOk;
  logic msTick;
  logic [5:0] nfNow, nfRise;
  logic [7:0] fatalCode;
  logic fatalHit;

  // Bus decode; reads are looked up in the setup cycle so the zero-wait access
  // cycle presents them from a flop, while writes commit only in the access cycle
  assign addrOk = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00) &&
                  (paddr[7:0] <= err_class_pkg::OFF_CLEAR);
  assign accessWrite = psel && penable && pwrite && addrOk;
  assign setupRead = psel && !penable && !pwrite && addrOk;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign prdata = rdata;
  // A write counts only at the edge where the master sees pready, never earlier
  assign clearReq = accessWrite && (paddr[7:0] == err_class_pkg::OFF_CLEAR) && pwdata[0];

  assign msTick = (msPre == 32'(CYCLES_PER_MS - 1));

  // Non-fatal causes, in code priority order
  assign nfNow[0] = (phase == err_class_pkg::RUNNING) &&
                    (cycleMs > err_class_pkg::CYCLE_OVERRUN_MS);
  assign nfNow[1] = faults.ioVerifyMismatch;
  assign nfNow[2] = faults.remoteFault;
  assign nfNow[3] = faults.dualBusFault | faults.dualCpuFault |
                    faults.dualMemFault;
  assign nfNow[4] = faults.batteryLow;
  assign nfNow[5] = 1'b0;
  // Per-source edge against the sticky flag, so each cause posts its code at most once
  // until cleared; a shared dual-CPU flag would swallow a second dual fault
  assign nfRise[0] = nfNow[0] && !sr253[err_class_pkg::SR253_CYCLE];
  assign nfRise[1] = nfNow[1] && !sr253[err_class_pkg::SR253_VERIFY];
  assign nfRise[2] = nfNow[2] && !sr253[err_class_pkg::SR253_REMOTE];
  assign nfRise[3] = (faults.dualBusFault && !sr254[err_class_pkg::SR254_DUAL_BUS]) ||
                     (faults.dualCpuFault && !sr254[err_class_pkg::SR254_DUAL_CPU]) ||
                     (faults.dualMemFault && !sr254[err_class_pkg::SR254_DUAL_MEM]);
  assign nfRise[4] = nfNow[4] && !sr253[err_class_pkg::SR253_BATTERY];
  assign nfRise[5] = 1'b0;

  // Fatal cause and its code; later checks take priority in this chain
  always_comb begin
    fatalHit = 1'b0;
    fatalCode = err_class_pkg::CODE_NONE;
    if (faults.ioWordMismatch) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_IO_WORDS;
    end
    if (faults.tooManyUnits) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_TOO_MANY;
    end
    if (faults.ioBusFault) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_IO_BUS_BASE | {5'h00, faults.ioBusRack};
    end
    if (faults.noEndInstr) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_NO_END;
    end
    if (faults.memFault) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_MEMORY;
    end
    if (fatal_alarm_instr) begin
      fatalHit = 1'b1;
      if (cycleMs >= err_class_pkg::LATE_FATAL_LO_MS &&
          cycleMs <= err_class_pkg::LATE_FATAL_HI_MS) begin
        fatalCode = err_class_pkg::CODE_LATE_FATAL;
      end else begin
        fatalCode = user_alarm_code;
      end
    end
    if (cycleMs > wdMax) begin
      fatalHit = 1'b1;
      fatalCode = err_class_pkg::CODE_NONE;
    end
  end

  // Next-state logic for phase, codes, flags, timers and registers
  always_comb begin
    logic [7:0] newCode;
    logic popReq;
    newCode = err_class_pkg::CODE_NONE;
    popReq = 1'b0;
    next_phase = phase;
    next_mode = mode;
    next_wdMax = wdMax;
    next_alarmCode = alarmCode;
    next_pend = pend;
    next_pendCount = pendCount;
    next_sr253 = sr253;
    next_sr254 = sr254;
    next_sr255 = sr255;
    next_fatalAddr = fatalAddr;
    next_powerDown = powerDown;
    next_rdata = rdata;
    next_msPre = msTick ? 32'h00000000 : msPre + 32'h00000001;

    // Register writes
    if (accessWrite && paddr[7:0] == err_class_pkg::OFF_CTRL) begin
      next_mode = pwdata[1:0];
    end
    if (accessWrite && paddr[7:0] == err_class_pkg::OFF_WD_MAX) begin
      next_wdMax = pwdata[7:0];
    end

    // Clearing honoured only in program mode; otherwise silently refused
    if (clearReq && mode == err_class_pkg::MODE_PROGRAM) begin
      next_alarmCode = err_class_pkg::CODE_NONE;
      next_pendCount = 3'd0;
      next_sr253 = 16'h0000;
      next_sr254 = 16'h0000;
      next_sr255 = 16'h0000;
      next_fatalAddr = 20'h00000;
      if (phase == err_class_pkg::FATAL_STOP && !supplyLost) begin
        next_phase = err_class_pkg::WAIT_START;
        next_powerDown = 1'b0;
      end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    if (nfNow[4]) next_sr253[err_class_pkg::SR253_BATTERY] = 1'b1;
    if (nfNow[0]) next_sr253[err_class_pkg::SR253_CYCLE] = 1'b1;
    if (nfNow[1]) next_sr253[err_class_pkg::SR253_VERIFY] = 1'b1;
    if (nfNow[2]) next_sr253[err_class_pkg::SR253_REMOTE] = 1'b1;
    if (faults.dualBusFault) next_sr254[err_class_pkg::SR254_DUAL_BUS] = 1'b1;
    if (faults.dualCpuFault) next_sr254[err_class_pkg::SR254_DUAL_CPU] = 1'b1;
    if (faults.dualMemFault) next_sr254[err_class_pkg::SR254_DUAL_MEM] = 1'b1;
    if (faults.instrExecFault) next_sr255[err_class_pkg::SR255_EXEC_FAULT] = 1'b1;

    // Cycle watchdog in milliseconds, restarted at each scan end
    next_cycleMs = cycleMs;
    if (phase != err_class_pkg::RUNNING || cycleEnd) begin
      next_cycleMs = 8'h00;
    end else if (msTick && cycleMs != 8'hFF) begin
      next_cycleMs = cycleMs + 8'h01;
    end
    // Supply loss duration
    next_lossMs = lossMs;
    if (!supplyLost) begin
      next_lossMs = 8'h00;
    end else if (msTick && lossMs != 8'hFF) begin
      next_lossMs = lossMs + 8'h01;
    end

    // Non-fatal codes: newly raised causes and user alarm instruction
    if (phase == err_class_pkg::RUNNING) begin
      newCode = pick_code(nfRise, faults.remoteUnit);
      if (nonfatal_alarm_instr) begin
        if (user_alarm_code == err_class_pkg::CODE_NONE) begin
          popReq = 1'b1;
        end else begin
          newCode = user_alarm_code;
        end
      end
    end
    // A full queue drops later codes; the sticky flags still record each cause
    if (popReq) begin
      next_alarmCode = (pendCount != 3'd0) ? pend[0] : err_class_pkg::CODE_NONE;
      for (int i = 0; i < err_class_pkg::PEND_DEPTH - 1; i++) begin
        next_pend[i] = pend[i + 1];
      end
      if (pendCount != 3'd0) next_pendCount = pendCount - 3'd1;
    end else if (newCode != err_class_pkg::CODE_NONE) begin
      if (alarmCode == err_class_pkg::CODE_NONE) begin
        next_alarmCode = newCode;
      end else if (pendCount != 3'(err_class_pkg::PEND_DEPTH)) begin
        next_pend[pendCount[1:0]] = newCode;
        next_pendCount = pendCount + 3'd1;
      end
    end

    // Phase sequencing; fatal outranks anything non-fatal
    unique case (phase)
      err_class_pkg::WAIT_START: begin
        if (startInput) next_phase = err_class_pkg::WAIT_REMOTE;
      end
      err_class_pkg::WAIT_REMOTE: begin
        if (!startInput) begin
          next_phase = err_class_pkg::WAIT_START;
        end else if (remotePowerOk && terminatorCount == 4'd1) begin
          next_phase = err_class_pkg::RUNNING;
        end
      end
      err_class_pkg::RUNNING: begin
        if (fatalHit) begin
          next_phase = err_class_pkg::FATAL_STOP;
          next_alarmCode = fatalCode;
          if (fatal_alarm_instr) next_fatalAddr = instrAddress;
        end
      end
      err_class_pkg::FATAL_STOP: begin
      end
    endcase
    // Long supply loss overrides every phase and blanks the code
    if (lossMs >= err_class_pkg::POWER_LOSS_MS) begin
      next_phase = err_class_pkg::FATAL_STOP;
      next_powerDown = 1'b1;
      next_alarmCode = err_class_pkg::CODE_NONE;
    end

    // Read data captured in the setup cycle, presented in the access cycle;
    // a refused read returns zero instead of aliasing a register by low byte
    if (psel && !penable && !pwrite && !addrOk) begin
      next_rdata = 32'h00000000;
    end
    if (setupRead) begin
      unique case (paddr[7:0])
        err_class_pkg::OFF_CTRL: next_rdata = {30'h00000000, mode};
        err_class_pkg::OFF_STATUS: next_rdata = {18'h00000, pendCount, powerDown,
                                                 2'(phase), 1'b0, front};
        err_class_pkg::OFF_SR253: next_rdata = {16'h0000, sr253[15:8], alarmCode};
        err_class_pkg::OFF_SR254_255: next_rdata = {sr255, sr254};
        err_class_pkg::OFF_FATAL_ADDR: next_rdata = {12'h000, fatalAddr};
        err_class_pkg::OFF_WD_MAX: next_rdata = {24'h000000, wdMax};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= err_class_pkg::WAIT_START;
      mode <= err_class_pkg::CTRL_RESET;
      wdMax <= err_class_pkg::WD_MAX_RESET_MS;
      alarmCode <= err_class_pkg::CODE_NONE;
      for (int i = 0; i < err_class_pkg::PEND_DEPTH; i++) begin
        pend[i] <= err_class_pkg::CODE_NONE;
      end
      pendCount <= 3'd0;
      sr253 <= 16'h0000;
      sr254 <= 16'h0000;
      sr255 <= 16'h0000;
      fatalAddr <= 20'h00000;
      msPre <= 32'h00000000;
      cycleMs <= 8'h00;
      lossMs <= 8'h00;
      powerDown <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      phase <= next_phase;
      mode <= next_mode;
      wdMax <= next_wdMax;
      alarmCode <= next_alarmCode;
      pend <= next_pend;
      pendCount <= next_pendCount;
      sr253 <= next_sr253;
      sr254 <= next_sr254;
      sr255 <= next_sr255;
      fatalAddr <= next_fatalAddr;
      msPre <= next_msPre;
      cycleMs <= next_cycleMs;
      lossMs <= next_lossMs;
      powerDown <= next_powerDown;
      rdata <= next_rdata;
    end
  end

  // Indicator decode straight from registered phase and flags
  always_comb begin
    front = '0;
    unique case (phase)
      err_class_pkg::WAIT_START, err_class_pkg::WAIT_REMOTE: begin
        front.powerLed = 1'b1;
      end
      err_class_pkg::RUNNING: begin
        front.powerLed = 1'b1;
        front.runLed = 1'b1;
        front.runOutput = 1'b1;
        front.outputsEnable = 1'b1;
        front.execEnable = 1'b1;
        front.alarmLed = (alarmCode != err_class_pkg::CODE_NONE) ||
                         (sr253[15:8] != 8'h00) || (sr254 != 16'h0000);
      end
      err_class_pkg::FATAL_STOP: begin
        front.powerLed = !powerDown;
        front.errLed = !powerDown;
      end
    endcase
  end

endmodule

// file: src/err_class_pkg.sv
// Purpose: Shared constants and carriers for the controller error classifier.
// Assumes: 10 MHz clock, APB register access with 32-bit data.
// Notes: Alarm codes are two-digit values held as one byte, upper digit in [7:4].
package err_class_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_IN_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
  localparam logic [7:0] CYCLE_OVERRUN_MS = 8'd100;
  localparam logic [7:0] POWER_LOSS_MS = 8'd10;
  localparam logic [7:0] WD_MAX_RESET_MS = 8'd130;
  localparam logic [7:0] LATE_FATAL_LO_MS = 8'd120;
  localparam logic [7:0] LATE_FATAL_HI_MS = 8'd130;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SR253 = 8'h08;
  localparam logic [7:0] OFF_SR254_255 = 8'h0C;
  localparam logic [7:0] OFF_FATAL_ADDR = 8'h10;
  localparam logic [7:0] OFF_WD_MAX = 8'h14;
  localparam logic [7:0] OFF_CLEAR = 8'h18;
  // Controller modes held in CTRL[1:0]
  localparam logic [1:0] MODE_PROGRAM = 2'h0;
  localparam logic [1:0] MODE_MONITOR = 2'h1;
  localparam logic [1:0] MODE_RUN = 2'h2;
  localparam logic [1:0] CTRL_RESET = MODE_PROGRAM;
  // Alarm codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_CYCLE_OVERRUN = 8'hF8;
  localparam logic [7:0] CODE_IO_VERIFY = 8'hE7;
  localparam logic [7:0] CODE_REMOTE_BASE = 8'hB0;
  localparam logic [7:0] CODE_DUAL_CPU = 8'hD0;
  localparam logic [7:0] CODE_BATTERY = 8'hF7;
  localparam logic [7:0] CODE_MEMORY = 8'hF1;
  localparam logic [7:0] CODE_NO_END = 8'hF0;
  localparam logic [7:0] CODE_IO_BUS_BASE = 8'hC0;
  localparam logic [7:0] CODE_TOO_MANY = 8'hE1;
  localparam logic [7:0] CODE_IO_WORDS = 8'hE0;
  localparam logic [7:0] CODE_LATE_FATAL = 8'h9F;
  // Flag positions in the special relay words
  localparam int SR253_BATTERY = 8;
  localparam int SR253_CYCLE = 9;
  localparam int SR253_VERIFY = 10;
  localparam int SR253_REMOTE = 12;
  localparam int SR254_DUAL_BUS = 8;
  localparam int SR254_DUAL_CPU = 10;
  localparam int SR254_DUAL_MEM = 11;
  localparam int SR255_EXEC_FAULT = 3;
  localparam int PEND_DEPTH = 4;

  // Conditions reported by the rest of the CPU
  typedef struct packed {
    logic batteryLow;
    logic ioVerifyMismatch;
    logic remoteFault;
    logic [2:0] remoteUnit;
    logic dualBusFault;
    logic dualCpuFault;
    logic dualMemFault;
    logic memFault;
    logic noEndInstr;
    logic ioBusFault;
    logic [2:0] ioBusRack;
    logic tooManyUnits;
    logic ioWordMismatch;
    logic instrExecFault;
  } fault_in_t;

  // Front indicators and run control
  typedef struct packed {
    logic powerLed;
    logic runLed;
    logic alarmLed;
    logic errLed;
    logic runOutput;
    logic outputsEnable;
    logic execEnable;
  } front_t;

  typedef enum logic [1:0] {
    WAIT_START,
    WAIT_REMOTE,
    RUNNING,
    FATAL_STOP
  } phase_t;
endpackage

// file: tb/controller_error_classifier_monitor.sv
// Purpose: Concurrent checks on the error classifier ports.
// Assumes: One clock domain; reset_n asynchronous, active low.
// Notes: Bound from the bench top; watches the design's inputs and outputs, drives nothing.
`timescale 1ns/1ns
module controller_error_classifier_monitor #(
  parameter int CYCLES_PER_MS = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic startInput,
  input wire logic remotePowerOk,
  input wire logic [3:0] terminatorCount,
  input wire logic supplyLost,
  input wire logic cycleEnd,
  input wire logic nonfatal_alarm_instr,
  input wire logic fatal_alarm_instr,
  input wire logic [7:0] user_alarm_code,
  input wire logic [19:0] instrAddress,
  input wire err_class_pkg::fault_in_t faults,
  input wire err_class_pkg::front_t front
);
  logic [31:0] lossCount;
  logic [31:0] next_lossCount;

  // Length of the present supply loss; saturates so a long outage cannot wrap
  always_comb begin
    next_lossCount = 32'h0;
    if (supplyLost) begin
      next_lossCount = lossCount + ((lossCount < 32'h00FFFFFF) ? 32'h1 : 32'h0);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lossCount <= 32'h0;
    end else begin
      lossCount <= next_lossCount;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable && paddr > 32'h18 |-> pslverr)
    else $error("unmapped access not refused");
  a_stop_run_off: assert property (!front.execEnable |-> !front.runOutput)
    else $error("RUN output on while execution stopped");
  a_fatal_outs_off: assert property (front.errLed |->
    !front.runOutput && !front.outputsEnable && !front.execEnable)
    else $error("outputs live during fatal stop");
  a_remote_hold: assert property ((!remotePowerOk || terminatorCount != 4'h1) &&
    !front.execEnable |=> !front.execEnable)
    else $error("execution began without remote I/O ready");
  a_running_front: assert property (front.execEnable |->
    front.powerLed && front.runLed && !front.errLed && front.runOutput)
    else $error("wrong indicators while running");
  a_mem_fatal: assert property (front.execEnable && faults.memFault && !supplyLost |=>
    front.errLed && !front.execEnable)
    else $error("memory fault did not stop execution");
  a_user_fatal: assert property (front.execEnable && fatal_alarm_instr && !supplyLost |=>
    front.errLed && !front.runOutput)
    else $error("fatal alarm instruction did not stop");
  a_loss_dark: assert property (lossCount >= 11 * CYCLES_PER_MS |-> front == '0)
    else $error("indicators lit after long supply loss");
  a_power_dark: assert property (!front.powerLed |-> front == '0)
    else $error("indicator lit with power indicator dark");
endmodule

// file: tb/tb_controller_error_classifier.sv
// Purpose: Self-checking bench for the error classifier over APB.
// Assumes: Zero-wait APB slave; one millisecond shortened to 10 clocks.
// Notes: Scan-end pulses come from a background process gated by cycOn.
`timescale 1ns/1ns
module tb_controller_error_classifier;
  localparam int MS = 10;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, lastErr, cycOn;
  logic startInput, remotePowerOk, supplyLost, cycleEnd, nonfatal_alarm_instr, fatal_alarm_instr;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] terminatorCount;
  logic [7:0] user_alarm_code;
  logic [19:0] instrAddress;
  err_class_pkg::fault_in_t faults;
  err_class_pkg::front_t front;
  int mismatches, checks;
  int scanCnt = 0;
  logic [7:0] nfCode [6] = '{err_class_pkg::CODE_BATTERY, err_class_pkg::CODE_IO_VERIFY,
    8'hB3, err_class_pkg::CODE_DUAL_CPU, err_class_pkg::CODE_DUAL_CPU, 8'hD0};
  logic [31:0] nfOff [6] = '{32'h08, 32'h08, 32'h08, 32'h0C, 32'h0C, 32'h0C};
  logic [31:0] nfBit [6] = '{32'h100, 32'h400, 32'h1000, 32'h400, 32'h100, 32'h800};
  logic [7:0] fCode [5] = '{8'hF1, 8'hF0, 8'hC5, 8'hE1, 8'hE0};
  logic [1:0] modes [2] = '{err_class_pkg::MODE_RUN, err_class_pkg::MODE_MONITOR};

  controller_error_classifier #(.CYCLES_PER_MS(MS)) u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .startInput(startInput), .remotePowerOk(remotePowerOk), .terminatorCount(terminatorCount),
    .supplyLost(supplyLost), .cycleEnd(cycleEnd), .nonfatal_alarm_instr(nonfatal_alarm_instr),
    .fatal_alarm_instr(fatal_alarm_instr), .user_alarm_code(user_alarm_code),
    .instrAddress(instrAddress), .faults(faults), .front(front));

  always #50 clk = ~clk;

  // Scan end every 2 ms keeps the watchdog quiet unless a test stops it
  always @(posedge clk) begin
    scanCnt <= (scanCnt >= 2 * MS - 1) ? 0 : scanCnt + 1;
    cycleEnd <= cycOn && (scanCnt == 0);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q & mask, exp);
  endtask

  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    do begin
      apb(1'b0, 32'h04, 32'h0);
      n++;
    end while (q[9:8] !== p && n < 100);
    chk({30'h0, q[9:8]}, {30'h0, p});
  endtask

  task automatic instr(input logic fatal, input logic [7:0] c);
    @(posedge clk);
    fatal_alarm_instr <= fatal;
    nonfatal_alarm_instr <= !fatal;
    user_alarm_code <= c;
    @(posedge clk);
    fatal_alarm_instr <= 1'b0;
    nonfatal_alarm_instr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Clearing is only honoured in program mode, so switch there first
  task automatic recover();
    apb(1'b1, 32'h00, {30'h0, err_class_pkg::MODE_PROGRAM});
    apb(1'b1, 32'h18, 32'h1);
    wait_phase(2'h2);
  endtask

  function automatic err_class_pkg::fault_in_t mk(input int k);
    err_class_pkg::fault_in_t f;
    f = '0;
    case (k)
      0: f.batteryLow = 1'b1;
      1: f.ioVerifyMismatch = 1'b1;
      2: f = {3'b001, 3'h3, 12'h0};
      3: f.dualCpuFault = 1'b1;
      4: f.dualBusFault = 1'b1;
      5: f.dualMemFault = 1'b1;
      6: f.memFault = 1'b1;
      7: f.noEndInstr = 1'b1;
      8: f = {12'h001, 3'h5, 3'h0};
      9: f.tooManyUnits = 1'b1;
      10: f.ioWordMismatch = 1'b1;
      default: f.instrExecFault = 1'b1;
    endcase
    return f;
  endfunction

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs well under 10000 clocks
  initial begin
    #3000000;
    mismatches++;
    wrap_up();
  end

  initial begin
    {clk, reset_n, psel, penable, pwrite, cycOn, startInput, remotePowerOk} = 8'h00;
    {supplyLost, nonfatal_alarm_instr, fatal_alarm_instr} = 3'h0;
    {paddr, pwdata, terminatorCount, user_alarm_code, instrAddress} = '0;
    faults = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    chk({25'h0, front}, 32'h40);
    rd_chk(32'h00, 32'h3, 32'h0);
    rd_chk(32'h14, 32'hFF, 32'h82);
    rd_chk(32'h40, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
    cycOn <= 1'b1;
    repeat (20) @(posedge clk);
    rd_chk(32'h04, 32'h301, 32'h0);
    rd_chk(32'h08, 32'hFF, 32'h0);
    startInput <= 1'b1;
    terminatorCount <= 4'h2;
    remotePowerOk <= 1'b1;
    wait_phase(2'h1);
    repeat (20) @(posedge clk);
    rd_chk(32'h04, 32'h364, 32'h140);
    rd_chk(32'h08, 32'hFF, 32'h0);
    terminatorCount <= 4'h1;
    wait_phase(2'h2);
    chk({25'h0, front} & 32'h6F, 32'h67);
    supplyLost <= 1'b1;
    repeat (5 * MS) @(posedge clk);
    supplyLost <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, front.execEnable}, 32'h1);
    $display("test init done");
    for (int k = 0; k < 6; k++) begin
      faults <= mk(k);
      repeat (3) @(posedge clk);
      chk({25'h0, front}, 32'h77);
      rd_chk(32'h08, 32'hFF, {24'h0, nfCode[k]});
      rd_chk(nfOff[k], nfBit[k], nfBit[k]);
      faults <= '0;
      instr(1'b0, 8'h00);
      rd_chk(32'h08, 32'hFF, 32'h0);
    end
    faults <= mk(11);
    repeat (3) @(posedge clk);
    rd_chk(32'h0C, 32'h80000, 32'h80000);
    faults <= '0;
    instr(1'b0, 8'h42);
    rd_chk(32'h08, 32'hFF, 32'h42);
    instr(1'b0, 8'h99);
    instr(1'b0, 8'h00);
    rd_chk(32'h08, 32'hFF, 32'h99);
    instr(1'b0, 8'h00);
    rd_chk(32'h08, 32'hFF, 32'h0);
    $display("test nonfatal done");
    cycOn <= 1'b0;
    repeat (110 * MS) @(posedge clk);
    rd_chk(32'h08, 32'h2FF, 32'h2F8);
    chk({31'h0, front.execEnable}, 32'h1);
    repeat (12 * MS) @(posedge clk);
    instrAddress <= 20'h12345;
    instr(1'b1, 8'h33);
    rd_chk(32'h08, 32'hFF, 32'h9F);
    rd_chk(32'h10, 32'hFFFFF, 32'h12345);
    chk({25'h0, front} & 32'h6F, 32'h48);
    cycOn <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 32'h00, {30'h0, modes[m]});
      apb(1'b1, 32'h18, 32'h1);
      rd_chk(32'h04, 32'h300, 32'h300);
    end
    recover();
    rd_chk(32'h08, 32'hFF, 32'h0);
    instr(1'b1, 8'h07);
    rd_chk(32'h08, 32'hFF, 32'h07);
    recover();
    $display("test user fatal done");
    for (int k = 6; k < 11; k++) begin
      faults <= mk(k);
      repeat (3) @(posedge clk);
      chk({25'h0, front} & 32'h6F, 32'h48);
      rd_chk(32'h08, 32'hFF, {24'h0, fCode[k - 6]});
      faults <= '0;
      recover();
    end
    faults <= mk(0) | mk(6);
    repeat (3) @(posedge clk);
    chk({25'h0, front} & 32'h6F, 32'h48);
    faults <= '0;
    recover();
    apb(1'b1, 32'h14, 32'd20);
    cycOn <= 1'b0;
    repeat (30 * MS) @(posedge clk);
    chk({25'h0, front} & 32'h6F, 32'h48);
    rd_chk(32'h08, 32'hFF, 32'h0);
    apb(1'b1, 32'h14, 32'd130);
    cycOn <= 1'b1;
    recover();
    supplyLost <= 1'b1;
    repeat (12 * MS) @(posedge clk);
    chk({25'h0, front}, 32'h0);
    rd_chk(32'h08, 32'hFF, 32'h0);
    supplyLost <= 1'b0;
    $display("test fatal done");
    wrap_up();
  end
endmodule

bind controller_error_classifier controller_error_classifier_monitor #(
  .CYCLES_PER_MS(CYCLES_PER_MS)
) u_mon (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .startInput(startInput), .remotePowerOk(remotePowerOk), .terminatorCount(terminatorCount),
  .supplyLost(supplyLost), .cycleEnd(cycleEnd), .nonfatal_alarm_instr(nonfatal_alarm_instr),
  .fatal_alarm_instr(fatal_alarm_instr), .user_alarm_code(user_alarm_code),
  .instrAddress(instrAddress), .faults(faults), .front(front));
